// ==== core/spiesc_top.sv ====
// Purpose: Control, status and error logic of an SPI master/slave port
// Assumes: Serial pins are asynchronous and pass two flip-flops before use
// Notes: Minimal shift engine included so the flags have real causes
`timescale 1ns/1ps
module spiesc_top
	import spiesc_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ss_b_in,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_b,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_b,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_b,
	output logic             tx_irq_req,
	output logic             err_irq_req
);
	initial begin
		if (DATA_W != BITS_PER_XFER) $error("DATA_W must equal eight");
	end

	logic rst_m_r, rst_sync_b;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_r    <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_m_r    <= 1'b1;
			rst_sync_b <= rst_m_r;
		end
	end

	// Pin synchronisers; first stage read by second stage only
	logic [3:0] pin_m_r, pin_s_r, pin_d_r;
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_m_r <= 4'hf;
			pin_s_r <= 4'hf;
			pin_d_r <= 4'hf;
		end else begin
			pin_m_r <= {ss_b_in, sck_in, mosi_in, miso_in};
			pin_s_r <= pin_m_r;
			pin_d_r <= pin_s_r;
		end
	end
	wire ss_b_s   = pin_s_r[3];
	wire sck_s    = pin_s_r[2];
	wire mosi_s   = pin_s_r[1];
	wire miso_s   = pin_s_r[0];
	wire ss_fall  = pin_d_r[3] & ~ss_b_s;
	wire ss_rise  = ~pin_d_r[3] & ss_b_s;
	wire sck_edge = pin_d_r[2] ^ sck_s;

	// Register state
	logic [7:0]      ctrl_r, ctrl_nxt;
	logic            done_r, write_collision_flag_r, serr_r, mode_fault_flag_r;
	logic            done_seen_r, write_collision_flag_seen_r, mode_fault_flag_seen_r;
	logic            ack_r;
	spiesc_state_e   st_r;
	logic [7:0]      shift_r;
	logic [3:0]      bitcnt_r;
	logic [6:0]      div_r;
	logic            sck_int_r;
	logic            slv_phase_r;
	logic            samp_m_r;

	wire enable     = ctrl_r[B_ENABLE];
	wire sel_ignore = ctrl_r[B_SEL_IGN];
	wire master     = ctrl_r[B_MASTER];
	wire idle_lvl   = ctrl_r[B_IDLE_LVL];
	wire phase      = ctrl_r[B_PHASE];
	wire [2:0] rate = {ctrl_r[B_RATE_HI], ctrl_r[B_RATE_MID], ctrl_r[B_RATE_LO]};

	// Half period in core cycles: divisor/2; reserved codes give zero and block a master start
	function automatic logic [6:0] half_div(input logic [2:0] code);
		case (code)
			3'h1: half_div = 7'h02;
			3'h2: half_div = 7'h04;
			3'h3: half_div = 7'h08;
			3'h4: half_div = 7'h10;
			3'h5: half_div = 7'h20;
			3'h6: half_div = 7'h40;
			default: half_div = 7'h00;
		endcase
	endfunction

	// Bus decode; one-cycle answer via wait state
	wire req      = (avs_read | avs_write) & ~ack_r;
	wire hit_ctrl = req & (avs_address == CTRL_IDX);
	wire hit_stat = req & (avs_address == STAT_IDX);
	wire hit_data = req & (avs_address == DATA_IDX);
	wire ctrl_wr  = hit_ctrl & avs_write;
	wire data_wr  = hit_data & avs_write;
	wire data_rd  = hit_data & avs_read;
	wire busy     = (st_r != SPIESC_IDLE);

	// Select honoured unless ignored; slave with phase zero always honours it
	wire ss_used   = ~sel_ignore | (~master & ~phase);
	wire mode_fault_flag_set  = enable & master & ~sel_ignore & ~ss_b_s;
	wire write_collision_flag_set  = enable & data_wr & busy;
	wire m_start   = enable & master & data_wr & ~busy & (half_div(rate) != 7'h00);
	wire slv_sel   = ss_used ? ~ss_b_s : 1'b1;
	wire serr_set  = enable & ~master & ss_used & ss_rise & busy;

	// Clock edge events for the shifter
	wire div_tick  = master & busy & (div_r == 7'h01);
	wire m_edge    = div_tick;
	wire s_edge    = ~master & slv_sel & sck_edge;
	wire sh_edge   = m_edge | s_edge;
	// Edge leaving idle is the first of each pair
	wire leave_idle = master ? (sck_int_r == idle_lvl) : (sck_s != idle_lvl);
	// Master samples one core cycle after its own clock event. The pin
	// shows the clock a cycle late and the returning data line still has
	// to pass the synchroniser, so an undelayed sample would take the
	// previous bit. Holding the shift one cycle also keeps the data line
	// steady across the pin edge at which the far side samples it.
	// The delay is one cycle, below the shortest half period of two.
	wire m_samp_now = m_edge & (leave_idle ^ phase);
	wire s_samp_now = s_edge & (leave_idle ^ phase);
	wire sample_ev  = master ? samp_m_r : s_samp_now;
	wire xfer_end   = sample_ev & (bitcnt_r == 4'h7);
	wire rx_bit     = master ? miso_s : mosi_s;
	wire [7:0] rx_byte = {shift_r[6:0], rx_bit};

	// Control register next value; mode fault knocks out enable and master
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr)
			ctrl_nxt = avs_writedata[7:0];
		if (mode_fault_flag_set) begin
			ctrl_nxt[B_ENABLE] = 1'b0;
			ctrl_nxt[B_MASTER] = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_r <= CTRL_RESET;
			ack_r  <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			ack_r  <= req;
		end
	end

	// Mode fault: set wins; clear needs seen-on-read then control write
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mode_fault_flag_r      <= 1'b0;
			mode_fault_flag_seen_r <= 1'b0;
		end else if (mode_fault_flag_set) begin
			mode_fault_flag_r      <= 1'b1;
			mode_fault_flag_seen_r <= 1'b0;
		end else if (ctrl_wr & mode_fault_flag_seen_r) begin
			mode_fault_flag_r      <= 1'b0;
			mode_fault_flag_seen_r <= 1'b0;
		end else if (hit_stat & avs_read & mode_fault_flag_r) begin
			mode_fault_flag_seen_r <= 1'b1;
		end
	end

	// Write collision: status access then data access
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			write_collision_flag_r      <= 1'b0;
			write_collision_flag_seen_r <= 1'b0;
		end else if (write_collision_flag_set) begin
			write_collision_flag_r      <= 1'b1;
			write_collision_flag_seen_r <= 1'b0;
		end else if (hit_data & write_collision_flag_seen_r) begin
			write_collision_flag_r      <= 1'b0;
			write_collision_flag_seen_r <= 1'b0;
		end else if (hit_stat & write_collision_flag_r) begin
			write_collision_flag_seen_r <= 1'b1;
		end
	end

	// Transfer done: status read seeing it then data read
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			done_r      <= 1'b0;
			done_seen_r <= 1'b0;
		end else if (xfer_end) begin
			done_r      <= 1'b1;
			done_seen_r <= 1'b0;
		end else if (data_rd & done_seen_r) begin
			done_r      <= 1'b0;
			done_seen_r <= 1'b0;
		end else if (hit_stat & avs_read & done_r) begin
			done_seen_r <= 1'b1;
		end
	end

	// Early release: only disabling the port clears it
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b)
			serr_r <= 1'b0;
		else if (serr_set)
			serr_r <= 1'b1;
		else if (!enable)
			serr_r <= 1'b0;
	end

	// Shift engine; collision writes never touch it
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_r        <= SPIESC_IDLE;
			shift_r     <= 8'h00;
			bitcnt_r    <= 4'h0;
			div_r       <= 7'h00;
			sck_int_r   <= 1'b0;
			slv_phase_r <= 1'b0;
			samp_m_r    <= 1'b0;
		end else if (!enable) begin
			samp_m_r    <= 1'b0;
			st_r        <= SPIESC_IDLE;
			bitcnt_r    <= 4'h0;
			div_r       <= 7'h00;
			sck_int_r   <= idle_lvl;
			slv_phase_r <= 1'b0;
		end else begin
			// Pending master sample; dropped when a fault aborts the byte
			samp_m_r <= m_samp_now & ~(mode_fault_flag_set & busy);
			if (m_start) begin
				st_r      <= SPIESC_RUN;
				shift_r   <= avs_writedata[7:0];
				bitcnt_r  <= 4'h0;
				div_r     <= half_div(rate);
				sck_int_r <= idle_lvl;
			end else if (!master & !busy & data_wr) begin
				shift_r <= avs_writedata[7:0];
			end
			if (!master & slv_sel & !busy & (sck_edge | (phase == 1'b0 & ss_fall)))
				st_r <= SPIESC_RUN;
			if (m_edge) begin
				sck_int_r <= ~sck_int_r;
				div_r     <= half_div(rate);
			end else if (master & busy) begin
				div_r <= div_r - 7'h01;
			end
			if (sample_ev) begin
				shift_r  <= rx_byte;
				bitcnt_r <= bitcnt_r + 4'h1;
				slv_phase_r <= 1'b1;
				if (bitcnt_r == 4'h7)
					st_r <= master ? SPIESC_LAST : SPIESC_IDLE;
			end
			// Master holds one more half period to return the clock to idle
			if (st_r == SPIESC_LAST & m_edge)
				st_r <= SPIESC_IDLE;
			if (st_r == SPIESC_LAST & m_edge)
				sck_int_r <= idle_lvl;
			if (serr_set | (mode_fault_flag_set & busy))
				st_r <= SPIESC_IDLE;
			if (serr_set | (mode_fault_flag_set & busy))
				bitcnt_r <= 4'h0;
		end
	end

	// Receive buffer loads only while done is clear: no overrun detect
	wire [7:0] rx_q;
	spiesc_rxbuf #(
		.WIDTH(DATA_W)
	) u_rxbuf (
		.core_clk  (core_clk),
		.rst_sync_b(rst_sync_b),
		.load      (xfer_end & ~done_r),
		.wdata     (rx_byte),
		.rdata     (rx_q)
	);

	wire [7:0] stat_val = {done_r, write_collision_flag_r, serr_r, mode_fault_flag_r, 4'h0};
	wire [7:0] rd_mux   = (avs_address == CTRL_IDX) ? ctrl_r :
	                      (avs_address == STAT_IDX) ? stat_val :
	                      (avs_address == DATA_IDX) ? rx_q : 8'h00;
	wire drv_master = enable & master;
	wire drv_slave  = enable & ~master & slv_sel;

	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			avs_readdata    <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
			sck_out         <= 1'b0;
			sck_oe_b        <= 1'b1;
			mosi_out        <= 1'b0;
			mosi_oe_b       <= 1'b1;
			miso_out        <= 1'b0;
			miso_oe_b       <= 1'b1;
			tx_irq_req      <= 1'b0;
			err_irq_req     <= 1'b0;
		end else begin
			avs_readdata    <= {24'h000000, rd_mux};
			avs_waitrequest <= ~req;
			sck_out         <= drv_master ? sck_int_r : idle_lvl;
			sck_oe_b        <= ~drv_master;
			mosi_out        <= shift_r[7];
			mosi_oe_b       <= ~drv_master;
			miso_out        <= shift_r[7];
			miso_oe_b       <= ~drv_slave;
			tx_irq_req      <= done_r;
			// Collision and early release deliberately excluded
			err_irq_req     <= mode_fault_flag_r & ~sel_ignore;
		end
	end
endmodule // spiesc_top

// ==== core/spiesc_pkg.sv ====
// Purpose: Shared constants for the serial port control and status block
// Assumes: Avalon-MM word addressing, 8-bit registers in the low bits
// Notes: Offsets are register indices; byte address is four times the index
package spiesc_pkg;
	localparam logic [7:0] CTRL_IDX    = 8'hc3;
	localparam logic [7:0] STAT_IDX    = 8'hc4;
	localparam logic [7:0] DATA_IDX    = 8'hc5;
	localparam logic [7:0] CTRL_RESET  = 8'h14;
	localparam int         B_RATE_HI   = 7;
	localparam int         B_ENABLE    = 6;
	localparam int         B_SEL_IGN   = 5;
	localparam int         B_MASTER    = 4;
	localparam int         B_IDLE_LVL  = 3;
	localparam int         B_PHASE     = 2;
	localparam int         B_RATE_MID  = 1;
	localparam int         B_RATE_LO   = 0;
	localparam int         B_DONE      = 7;
	localparam int         B_WRITE_COLLISION_FLAG      = 6;
	localparam int         B_SERR      = 5;
	localparam int         B_MODE_FAULT_FLAG      = 4;
	localparam int         BITS_PER_XFER = 8;
	typedef enum logic [1:0] {
		SPIESC_IDLE = 2'b00,
		SPIESC_RUN  = 2'b01,
		SPIESC_LAST = 2'b11
	} spiesc_state_e;
endpackage

// ==== core/spiesc_rxbuf.sv ====
// Purpose: Receive data holding register with registered read data
// Assumes: Caller decides when a new byte may be captured
// Notes: Captures only when load is high, so later bytes are dropped
`timescale 1ns/1ps
module spiesc_rxbuf #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst_sync_b,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);
	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b)
			rdata <= '0;
		else if (load)
			rdata <= wdata;
	end
endmodule // spiesc_rxbuf

// ==== tb/spiesc_sva.sv ====
// Purpose: Port-level checks for the serial port control block
// Assumes: Bus answers one cycle after the take edge
// Notes: Sees only top-level ports
`timescale 1ns/1ps
module spiesc_sva
	import spiesc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        ss_b_in,
	input wire logic        sck_oe_b,
	input wire logic        mosi_oe_b,
	input wire logic        miso_oe_b,
	input wire logic        tx_irq_req,
	input wire logic        err_irq_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer held too long");
	a_ack_latency: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("bus answer late");
	a_stat_rsvd: assert property (!avs_waitrequest && $past(avs_read && avs_address == STAT_IDX)
		|-> avs_readdata[3:0] == 4'h0 && avs_readdata[31:8] == 24'h0)
		else $error("reserved status bits set");
	a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read) &&
		!(avs_address inside {[CTRL_IDX:DATA_IDX]}) |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_fault_cause: assert property ($rose(err_irq_req) |-> !$past(ss_b_in) ||
		!$past(ss_b_in, 2) || !$past(ss_b_in, 3) || $past(avs_write))
		else $error("error request without select low");
	a_fault_stop: assert property ($rose(err_irq_req) |-> ##[0:2] (sck_oe_b && mosi_oe_b))
		else $error("port still driving after fault");
	a_master_pins: assert property (!sck_oe_b |-> !mosi_oe_b && miso_oe_b)
		else $error("master pin drive wrong");
	a_slave_pins: assert property (!miso_oe_b |-> sck_oe_b && mosi_oe_b)
		else $error("slave pin drive wrong");
	a_done_clear: assert property ($fell(tx_irq_req) |->
		$past(avs_read || avs_write, 2) || err_irq_req)
		else $error("done cleared without access");
endmodule // spiesc_sva

bind spiesc_top spiesc_sva u_sva (
	.core_clk(core_clk),
	.rst_b(rst_b),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.ss_b_in(ss_b_in),
	.sck_oe_b(sck_oe_b),
	.mosi_oe_b(mosi_oe_b),
	.miso_oe_b(miso_oe_b),
	.tx_irq_req(tx_irq_req),
	.err_irq_req(err_irq_req)
);

// ==== tb/spiesc_peer.sv ====
// Purpose: Remote serial slave that echoes the byte it last received
// Assumes: Idle-low clock, sample on rising edge, shift on falling edge
// Notes: Always selected, so its data line is always driven
`timescale 1ns/1ps
module spiesc_peer #(
	parameter logic [7:0] INIT = 8'h3c
) (
	input  wire logic       sck,
	input  wire logic       mosi,
	output logic            miso,
	output logic      [7:0] held
);
	logic bit_in;
	initial held = INIT;
	always @(posedge sck) bit_in <= mosi;
	always @(negedge sck) held <= {held[6:0], bit_in};
	assign miso = held[7];
endmodule // spiesc_peer

// ==== tb/spi_error_status_control_tb.sv ====
// Purpose: Self-checking bench for the serial port control block
// Assumes: One-cycle bus answer, divide-by-4 master rate
// Notes: Register rows first, then transfer, fault and slave cases
`timescale 1ns/1ps
module spi_error_status_control_tb
	import spiesc_pkg::*;
;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} spiesc_row_s;
	localparam spiesc_row_s ROWS [0:8] = '{'{1'b0, 8'hc3, 8'h00, 8'h14},
		'{1'b0, 8'hc4, 8'h00, 8'h00}, '{1'b0, 8'hc6, 8'h00, 8'h00},
		'{1'b1, 8'hc6, 8'hff, 8'h00}, '{1'b0, 8'hc6, 8'h00, 8'h00},
		'{1'b1, 8'hc3, 8'h2f, 8'h00}, '{1'b0, 8'hc3, 8'h00, 8'h2f},
		'{1'b1, 8'hc3, 8'hac, 8'h00}, '{1'b0, 8'hc3, 8'h00, 8'hac}};
	logic        core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address, peer_held;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        ss_b_in, bench_sck, sck_w, sck_out, sck_oe_b, mosi_w, mosi_out, mosi_oe_b;
	logic        miso_w, miso_out, miso_oe_b, peer_miso, tx_irq_req, err_irq_req;
	integer      n_errors, n_checks, n;
	assign sck_w = sck_oe_b ? bench_sck : sck_out;
	assign mosi_w = mosi_oe_b ? ~mosi_out : mosi_out;
	assign miso_w = miso_oe_b ? peer_miso : miso_out;
	spiesc_top dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ss_b_in(ss_b_in),
		.sck_in(sck_w), .sck_out(sck_out), .sck_oe_b(sck_oe_b), .mosi_in(mosi_w),
		.mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b), .miso_in(miso_w), .miso_out(miso_out),
		.miso_oe_b(miso_oe_b), .tx_irq_req(tx_irq_req), .err_irq_req(err_irq_req));
	spiesc_peer peer (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .held(peer_held));
	always #12.5 core_clk = ~core_clk;
	task complete_run;
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Holds the request until waitrequest is sampled low, then idles one edge
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		integer k;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) n_errors++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task idle(input integer c);
		repeat (c) @(posedge core_clk);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		complete_run;
	end
	initial begin
		core_clk = 0; rst_b = 0; avs_address = 0; avs_read = 0; avs_write = 0;
		avs_writedata = 0; ss_b_in = 1; bench_sck = 0; n_errors = 0; n_checks = 0;
		idle(5);
		rst_b <= 1'b1;
		idle(3);
		foreach (ROWS[i]) begin
			acc(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			if (!ROWS[i].w) chk("register row", {24'h0, ROWS[i].e}, q);
		end
		acc(1'b1, CTRL_IDX, 8'h51);
		acc(1'b1, DATA_IDX, 8'ha5);
		acc(1'b1, DATA_IDX, 8'h5a);
		n = 0;
		while (tx_irq_req !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		// The last pin clock edge lands a cycle after the request rises
		idle(2);
		chk("error request", 0, err_irq_req);
		chk("peer byte", 8'ha5, peer_held);
		// Done is still set, so the reply to this byte must not replace the buffered one
		acc(1'b1, DATA_IDX, 8'h0f);
		idle(60);
		chk("peer byte", 8'h0f, peer_held);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'hc0, q);
		chk("done request", 1, tx_irq_req);
		acc(1'b0, DATA_IDX, 8'h00); chk("data", 8'h3c, q);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h00, q);
		ss_b_in <= 1'b0;
		idle(6);
		chk("error request", 1, err_irq_req);
		acc(1'b0, CTRL_IDX, 8'h00); chk("control", 8'h01, q);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h10, q);
		ss_b_in <= 1'b1;
		idle(4);
		acc(1'b1, CTRL_IDX, 8'h51);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h00, q);
		acc(1'b0, CTRL_IDX, 8'h00); chk("control", 8'h51, q);
		acc(1'b1, CTRL_IDX, 8'h71);
		ss_b_in <= 1'b0;
		idle(6);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h00, q);
		chk("error request", 0, err_irq_req);
		ss_b_in <= 1'b1;
		idle(4);
		acc(1'b1, CTRL_IDX, 8'h40);
		ss_b_in <= 1'b0;
		idle(4);
		bench_sck <= 1'b1;
		idle(4);
		bench_sck <= 1'b0;
		idle(4);
		ss_b_in <= 1'b1;
		idle(6);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h20, q);
		chk("error request", 0, err_irq_req);
		acc(1'b1, CTRL_IDX, 8'h40);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h20, q);
		acc(1'b1, CTRL_IDX, 8'h00);
		acc(1'b0, STAT_IDX, 8'h00); chk("status", 8'h00, q);
		complete_run;
	end
endmodule // spi_error_status_control_tb
